/* File: anpr_pkg.sv */
// Contract
// [R1] Partner word bit 15: further page requested
// [R2] Partner word bit 14: partner acknowledgement
// [R3] Partner word bit 13: partner message page
// [R4] Partner word bit 12: partner can comply
// [R5] Partner toggle bit 11, code bits 10:0
// [R6] Expansion bit 4 latches fault, read clears
// [R7] Expansion bit 3: partner next page able
// [R8] Expansion bit 2 always reads one
// [R9] Expansion bit 1 latches page received, read clears
// [R10] Expansion bit 0 partner negotiates; 15:5 zero
// [R11] Advert bit 15 writable, bit 14 zero
// [R12] Advert bit 13 resets one; code resets 001
// [R13] Advert bit 12 comply acknowledge, writable
// [R14] Advert bit 11 toggles per sent page
// [R15] Software ignores and never writes reserved registers
// [R16] Feature bit 14 selects interrupt polarity
// [R17] Feature bit 13 read-only forced jam flag
// [R18] Software writes feature bit 15 as zero
// [R19] Software writes feature 12:4 zero; 3:0 ignored
// [R20] Each port owns independent register copy
`default_nettype none
package anpr_pkg;
    localparam int ANPR_PORTS = 4;
    localparam logic [4:0] ANPR_REG_LP_NP = 5'h05;
    localparam logic [4:0] ANPR_REG_EXP = 5'h06;
    localparam logic [4:0] ANPR_REG_ADV = 5'h07;
    localparam logic [4:0] ANPR_REG_FEAT = 5'h10;
    localparam int ANPR_EXP_PDF = 4;
    localparam int ANPR_EXP_LP_NP = 3;
    localparam int ANPR_EXP_NP_ABLE = 2;
    localparam int ANPR_EXP_PG_RX = 1;
    localparam int ANPR_EXP_LP_AN = 0;
    localparam int ANPR_ADV_RSV = 14;
    localparam int ANPR_ADV_TOGGLE = 11;
    localparam int ANPR_FEAT_POL = 14;
    localparam int ANPR_FEAT_JAM = 13;
    localparam logic [15:0] ANPR_LP_RST = 16'h0000;
    localparam logic [15:0] ANPR_ADV_RST = 16'h2001;
    localparam logic [15:0] ANPR_ADV_WMASK = 16'hBFFF;
    localparam logic [15:0] ANPR_FEAT_RST = 16'h0000;
    localparam logic [15:0] ANPR_FEAT_WMASK = 16'hDFF0;
    localparam logic [5:0] ANPR_PREAMBLE_ONES = 6'h20;
    localparam logic [4:0] ANPR_HDR_LAST = 5'h0C;
    localparam logic [4:0] ANPR_RD_BITS = 5'h10;
    localparam logic [4:0] ANPR_WR_BITS = 5'h12;
    localparam logic [1:0] ANPR_OP_RD = 2'h2;
    localparam logic [1:0] ANPR_OP_WR = 2'h1;

    typedef struct packed {
        logic page_rx;
        logic pd_fault;
        logic page_sent;
        logic lp_np_able;
        logic lp_an_able;
        logic jam_active;
        logic irq_req;
        logic [15:0] lp_word;
    } anpr_evt_t;

    typedef enum {ST_PRE, ST_HDR, ST_RTA, ST_RDATA, ST_WDATA} anpr_state_t;
endpackage : anpr_pkg
`default_nettype wire

/* File: anpr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module anpr_regs
    import anpr_pkg::*;
#(
    parameter logic [4:0] PHY_BASE = 5'h00
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // Negotiation logic, one entry per port
    input wire anpr_evt_t port_evt [ANPR_PORTS],
    output logic [15:0] adv_word [ANPR_PORTS],
    output logic [ANPR_PORTS-1:0] irq_pin
);

    // Four consecutive port addresses must fit
    if (PHY_BASE > 5'h1C) begin : g_bad_base
        $error("PHY_BASE leaves no room for four ports");
    end

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic mdc_s1_r;
    logic mdc_s2_r;
    logic mdc_s3_r;
    logic md_s1_r;
    logic md_s2_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_s1_r <= 1'b0;
            mdc_s2_r <= 1'b0;
            mdc_s3_r <= 1'b0;
            md_s1_r <= 1'b1;
            md_s2_r <= 1'b1;
        end else begin
            mdc_s1_r <= mdc;
            mdc_s2_r <= mdc_s1_r;
            mdc_s3_r <= mdc_s2_r;
            md_s1_r <= mdio_in;
            md_s2_r <= md_s1_r;
        end
    end

    logic mdc_rise;
    assign mdc_rise = mdc_s2_r & ~mdc_s3_r;

    ////////////////////////////////////////////////////////////////
    // Frame decoder

    anpr_state_t state_r;
    logic [5:0] ones_r;
    logic [4:0] cnt_r;
    logic [11:0] hdr_r;
    logic [16:0] rsh_r;
    logic [15:0] wsh_r;
    logic [1:0] port_r;
    logic [4:0] reg_r;

    logic [12:0] hdr_full;
    logic [4:0] phy_off;
    logic hdr_done;
    logic hdr_ok;
    logic rd_now;
    logic wr_now;
    logic [1:0] hdr_port;
    logic [15:0] rd_word;

    assign hdr_full = {hdr_r, md_s2_r};
    assign phy_off = hdr_full[9:5] - PHY_BASE;
    assign hdr_port = phy_off[1:0];
    assign hdr_done = mdc_rise && state_r == ST_HDR && cnt_r == ANPR_HDR_LAST;
    assign hdr_ok = hdr_done && hdr_full[12] && phy_off < 5'h04; // R20
    assign rd_now = hdr_ok && hdr_full[11:10] == ANPR_OP_RD;
    assign wr_now = mdc_rise && state_r == ST_WDATA && cnt_r == 5'h01;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_PRE;
            ones_r <= 6'h00;
            cnt_r <= 5'h00;
            hdr_r <= 12'h000;
            port_r <= 2'h0;
            reg_r <= 5'h00;
        end else if (mdc_rise) begin
            unique case (state_r)
                ST_PRE: begin
                    if (md_s2_r) begin
                        if (ones_r != ANPR_PREAMBLE_ONES) begin
                            ones_r <= ones_r + 6'h01;
                        end
                    end else begin
                        if (ones_r == ANPR_PREAMBLE_ONES) begin
                            state_r <= ST_HDR;
                            cnt_r <= 5'h00;
                        end
                        ones_r <= 6'h00;
                    end
                end
                ST_HDR: begin
                    hdr_r <= hdr_full[11:0];
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == ANPR_HDR_LAST) begin
                        port_r <= hdr_port;
                        reg_r <= hdr_full[4:0];
                        if (rd_now) begin
                            state_r <= ST_RTA;
                        end else if (hdr_ok && hdr_full[11:10] == ANPR_OP_WR) begin
                            state_r <= ST_WDATA;
                            cnt_r <= ANPR_WR_BITS;
                        end else begin
                            state_r <= ST_PRE;
                        end
                    end
                end
                ST_RTA: begin
                    state_r <= ST_RDATA;
                    cnt_r <= ANPR_RD_BITS;
                end
                ST_RDATA: begin
                    if (cnt_r == 5'h00) begin
                        state_r <= ST_PRE;
                    end else begin
                        cnt_r <= cnt_r - 5'h01;
                    end
                end
                ST_WDATA: begin
                    cnt_r <= cnt_r - 5'h01;
                    if (cnt_r == 5'h01) begin
                        state_r <= ST_PRE;
                    end
                end
            endcase
        end
    end

    // Write data shifter, turnaround bits fall off the top
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wsh_r <= 16'h0000;
        end else if (mdc_rise && state_r == ST_WDATA) begin
            wsh_r <= {wsh_r[14:0], md_s2_r};
        end
    end

    logic [15:0] wr_data;
    assign wr_data = {wsh_r[14:0], md_s2_r};

    // Read shifter and pin drive, updated just after each clock rise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsh_r <= 17'h00000;
            mdio_out <= 1'b1;
            mdio_oe <= 1'b0;
        end else if (mdc_rise) begin
            if (rd_now) begin
                rsh_r <= {1'b0, rd_word};
            end else if (state_r == ST_RTA
                         || (state_r == ST_RDATA && cnt_r != 5'h00)) begin
                mdio_out <= rsh_r[16];
                mdio_oe <= 1'b1;
                rsh_r <= {rsh_r[15:0], 1'b0};
            end else begin
                mdio_out <= 1'b1;
                mdio_oe <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Per-port registers

    logic [15:0] lp_word_r [ANPR_PORTS];
    logic [15:0] adv_r [ANPR_PORTS];
    logic [15:0] feat_r [ANPR_PORTS];
    logic [ANPR_PORTS-1:0] pdf_r;
    logic [ANPR_PORTS-1:0] pg_rx_r;
    logic [15:0] exp_view [ANPR_PORTS];
    logic [15:0] feat_view [ANPR_PORTS];

    for (genvar p = 0; p < ANPR_PORTS; p++) begin : g_port
        logic sel_rd_exp;
        logic sel_wr_adv;
        logic sel_wr_feat;
        logic [15:0] adv_base;

        assign sel_rd_exp = rd_now && hdr_port == 2'(p) && hdr_full[4:0] == ANPR_REG_EXP;
        assign sel_wr_adv = wr_now && port_r == 2'(p) && reg_r == ANPR_REG_ADV;
        assign sel_wr_feat = wr_now && port_r == 2'(p) && reg_r == ANPR_REG_FEAT;
        assign adv_base = sel_wr_adv
            ? (wr_data & ANPR_ADV_WMASK) : adv_r[p]; // R11 R12 R13

        assign exp_view[p] = {11'h000, pdf_r[p], port_evt[p].lp_np_able, 1'b1,
                              pg_rx_r[p], port_evt[p].lp_an_able}; // R7 R8 R10
        assign feat_view[p] = {feat_r[p][15:14], port_evt[p].jam_active,
                               feat_r[p][12:4], 4'h0}; // R17

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                lp_word_r[p] <= ANPR_LP_RST;
            end else if (port_evt[p].page_rx) begin
                lp_word_r[p] <= port_evt[p].lp_word; // R1 R2 R3 R4 R5
            end
        end

        // Latch-high flags, a new event beats a clearing read
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                pdf_r[p] <= 1'b0;
                pg_rx_r[p] <= 1'b0;
            end else begin
                pdf_r[p] <= port_evt[p].pd_fault | (pdf_r[p] & ~sel_rd_exp); // R6
                pg_rx_r[p] <= port_evt[p].page_rx | (pg_rx_r[p] & ~sel_rd_exp); // R9
            end
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                adv_r[p] <= ANPR_ADV_RST; // R12
            end else begin
                adv_r[p] <= adv_base;
                if (port_evt[p].page_sent) begin
                    adv_r[p][ANPR_ADV_TOGGLE] <= ~adv_base[ANPR_ADV_TOGGLE]; // R14
                end
            end
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                feat_r[p] <= ANPR_FEAT_RST;
            end else if (sel_wr_feat) begin
                feat_r[p] <= wr_data & ANPR_FEAT_WMASK; // R16
            end
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                irq_pin[p] <= 1'b0;
            end else begin
                irq_pin[p] <= port_evt[p].irq_req
                    ~^ feat_r[p][ANPR_FEAT_POL]; // R16
            end
        end

        assign adv_word[p] = adv_r[p];
    end

    // Read mux, unmapped addresses read as zero
    always_comb begin
        unique case (hdr_full[4:0])
            ANPR_REG_LP_NP: rd_word = lp_word_r[hdr_port];
            ANPR_REG_EXP: rd_word = exp_view[hdr_port];
            ANPR_REG_ADV: rd_word = adv_r[hdr_port];
            ANPR_REG_FEAT: rd_word = feat_view[hdr_port];
            default: rd_word = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_pdf_latch: assert property ( // R6
        port_evt[0].pd_fault |=> pdf_r[0] ##1 (pdf_r[0] || $past(rd_now)))
        else $error("fault flag not latched");
    chk_pdf_hold: assert property ( // R6
        pdf_r[1] && !rd_now |=> pdf_r[1])
        else $error("fault flag dropped without a read");
    chk_page_word: assert property ( // R9
        port_evt[2].page_rx |=> pg_rx_r[2] && lp_word_r[2] == $past(port_evt[2].lp_word))
        else $error("page not captured");
    chk_toggle_flip: assert property ( // R14
        port_evt[0].page_sent && !wr_now
        |=> adv_r[0][ANPR_ADV_TOGGLE] != $past(adv_r[0][ANPR_ADV_TOGGLE]))
        else $error("toggle bit did not flip");
    chk_irq_polarity: assert property ( // R16
        port_evt[3].irq_req |=> irq_pin[3] == $past(feat_r[3][ANPR_FEAT_POL]))
        else $error("interrupt pin polarity wrong");
    chk_adv_reserved: assert property ( // R11
        adv_r[1][ANPR_ADV_RSV] == 1'b0)
        else $error("advert reserved bit set");
    chk_exp_fixed: assert property ( // R8
        rd_now && hdr_full[4:0] == ANPR_REG_EXP
        |-> rd_word[ANPR_EXP_NP_ABLE] && rd_word[15:5] == 11'h000)
        else $error("expansion fixed bits wrong");
    chk_jam_view: assert property ( // R17
        rd_now && hdr_full[4:0] == ANPR_REG_FEAT
        |-> rd_word[ANPR_FEAT_JAM] == port_evt[hdr_port].jam_active)
        else $error("jam flag not shown");
    chk_read_drive: assert property ( // R20
        state_r == ST_RTA && mdc_rise |=> mdio_oe && !mdio_out)
        else $error("turnaround zero not driven");
    chk_read_release: assert property ( // R20
        state_r == ST_RDATA && cnt_r == 5'h00 && mdc_rise |=> !mdio_oe && mdio_out)
        else $error("data line not released after last bit");
    chk_unmatched_quiet: assert property ( // R20
        hdr_done && !hdr_ok |=> !mdio_oe [*8])
        else $error("refused frame drove the data line");
    chk_pg_hold: assert property ( // R9
        pg_rx_r[0] && !rd_now |=> pg_rx_r[0])
        else $error("page flag dropped without a read");
    chk_pdf_clear: assert property ( // R6
        rd_now && hdr_port == 2'h1 && hdr_full[4:0] == ANPR_REG_EXP && !port_evt[1].pd_fault
        |=> !pdf_r[1])
        else $error("fault flag not cleared by read");
    chk_lp_readonly: assert property ( // R5
        !port_evt[1].page_rx |=> $stable(lp_word_r[1]))
        else $error("partner word changed without a page");
    chk_adv_write: assert property ( // R11
        wr_now && port_r == 2'h1 && reg_r == ANPR_REG_ADV && !port_evt[1].page_sent
        |=> {adv_r[1][15], adv_r[1][13:12]} == {$past(wr_data[15]), $past(wr_data[13:12])}
            && !adv_r[1][ANPR_ADV_RSV])
        else $error("advert write not stored");
    chk_feat_write: assert property ( // R16
        wr_now && port_r == 2'h0 && reg_r == ANPR_REG_FEAT
        |=> feat_r[0][ANPR_FEAT_POL] == $past(wr_data[ANPR_FEAT_POL])
            && !feat_r[0][ANPR_FEAT_JAM])
        else $error("feature write not stored");
    chk_exp_flags: assert property ( // R7 R10
        rd_now && hdr_full[4:0] == ANPR_REG_EXP
        |-> rd_word[ANPR_EXP_LP_NP] == port_evt[hdr_port].lp_np_able
            && rd_word[ANPR_EXP_LP_AN] == port_evt[hdr_port].lp_an_able)
        else $error("partner ability bits wrong");
    chk_flag_view: assert property ( // R6 R9
        rd_now && hdr_full[4:0] == ANPR_REG_EXP
        |-> rd_word[ANPR_EXP_PDF] == pdf_r[hdr_port]
            && rd_word[ANPR_EXP_PG_RX] == pg_rx_r[hdr_port])
        else $error("latched flags not shown");

    // Main scenarios
    cov_read: cover property (rd_now);
    cov_write: cover property (wr_now);
    cov_fault_read: cover property (pdf_r[0] && rd_now);
    cov_toggle: cover property (port_evt[0].page_sent);
    cov_refused: cover property (hdr_done && !hdr_ok);

endmodule : anpr_regs
`default_nettype wire

/* File: anpr_lp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module anpr_lp_model
    import anpr_pkg::*;
(
    // Commands from the bench
    input wire logic [1:0] sel,
    input wire logic [2:0] pulse,
    input wire logic [15:0] word,
    // Partner and line levels per port
    input wire logic [3:0] np_able,
    input wire logic [3:0] an_able,
    input wire logic [3:0] jam,
    input wire logic [3:0] irq,
    // Events towards the block
    output var anpr_evt_t port_evt [ANPR_PORTS]
);
    ////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < ANPR_PORTS; i++) begin
            port_evt[i].page_rx = pulse[0] && (sel == i[1:0]);
            port_evt[i].pd_fault = pulse[1] && (sel == i[1:0]);
            port_evt[i].page_sent = pulse[2] && (sel == i[1:0]);
            port_evt[i].lp_np_able = np_able[i];
            port_evt[i].lp_an_able = an_able[i];
            port_evt[i].jam_active = jam[i];
            port_evt[i].irq_req = irq[i];
            // Word only valid with the page strobe
            port_evt[i].lp_word = port_evt[i].page_rx ? word : ~word;
        end
    end
endmodule : anpr_lp_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import anpr_pkg::*;
    logic ref_clk, rst_n, mdc, b_d, b_oe, mdio_out, mdio_oe;
    wire logic mdio_w;
    logic [1:0] sel;
    logic [2:0] pulse;
    logic [15:0] word, rd, w;
    logic [3:0] np_able, an_able, jam, irq, irq_pin;
    anpr_evt_t port_evt [ANPR_PORTS];
    logic [15:0] adv_word [ANPR_PORTS];
    int err_count, num_checks, cyc;
    int m_adv [4], m_feat [4], m_lp [4], m_pdf [4], m_prx [4];

    // Pull-up on the management data line
    assign mdio_w = mdio_oe ? mdio_out : (b_oe ? b_d : 1'b1);

    anpr_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_w),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_evt(port_evt),
        .adv_word(adv_word), .irq_pin(irq_pin));
    anpr_lp_model lp (.sel(sel), .pulse(pulse), .word(word), .np_able(np_able),
        .an_able(an_able), .jam(jam), .irq(irq), .port_evt(port_evt));

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic mclk();
        repeat (5) @(posedge ref_clk);
        mdc <= 1'b1;
        repeat (7) @(posedge ref_clk);
        mdc <= 1'b0;
    endtask : mclk

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd);
        logic [31:0] bits;
        bits = {2'b01, op, phy, rg, 2'b10, wd};
        repeat (32) begin
            b_d <= 1'b1;
            mclk();
        end
        for (int i = 31; i >= 0; i--) begin
            b_d <= bits[i];
            if (op == ANPR_OP_RD && i < 18) b_oe <= 1'b0;
            mclk();
            if (op == ANPR_OP_RD && i == 17) begin
                chk("turnaround", {15'h0000, phy > 5'h03}, {15'h0000, mdio_w});
            end else if (op == ANPR_OP_RD && i > 0 && i < 17) begin
                rd[i-1] = mdio_w;
            end else if (op == ANPR_OP_RD && i == 0) begin
                chk("release", 16'h0000, {15'h0000, mdio_oe});
            end
        end
        b_oe <= 1'b1;
        b_d <= 1'b1;
        @(posedge ref_clk);
    endtask : frame

    task automatic rdchk(input int p, input logic [4:0] rg, input logic [15:0] exp);
        frame(ANPR_OP_RD, p[4:0], rg, 16'h0000);
        chk($sformatf("reg%0h_port%0d", rg, p), exp, rd);
    endtask : rdchk

    task automatic rdchk6(input int p);
        rdchk(p, ANPR_REG_EXP, {11'h000, m_pdf[p][0], np_able[p], 1'b1, m_prx[p][0], an_able[p]});
        m_pdf[p] = 0;
        m_prx[p] = 0;
    endtask : rdchk6

    task automatic evt(input int p, input logic [2:0] k, input logic [15:0] wv);
        sel <= p[1:0];
        pulse <= k;
        word <= wv;
        @(posedge ref_clk);
        pulse <= 3'b000;
        @(posedge ref_clk);
    endtask : evt

    ////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 80000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        {mdc, pulse, word, sel, np_able, an_able, jam, irq} = '0;
        b_d = 1'b1;
        b_oe = 1'b1;
        rst_n = 1'b0;
        void'($urandom(32'h501E));
        for (int p = 0; p < 4; p++) begin
            m_adv[p] = 32'h2001;
            m_feat[p] = 0;
        end
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            rdchk(p, ANPR_REG_LP_NP, 16'h0000);
            rdchk6(p);
            rdchk(p, ANPR_REG_ADV, 16'h2001);
            rdchk(p, ANPR_REG_FEAT, 16'h0000);
        end
        @(posedge ref_clk);
        np_able <= 4'($urandom);
        an_able <= 4'($urandom);
        jam <= 4'($urandom);
        for (int p = 0; p < 4; p++) begin
            w = 16'($urandom);
            evt(p, 3'b001, w);
            m_lp[p] = w;
            m_prx[p] = 1;
            evt(p, 3'b010, 16'h0000);
            m_pdf[p] = 1;
            w = 16'($urandom);
            frame(ANPR_OP_WR, p[4:0], ANPR_REG_ADV, w);
            m_adv[p] = w & 16'hBFFF;
            evt(p, 3'b100, 16'h0000);
            m_adv[p] ^= 32'h0800;
            m_feat[p] = {1'($urandom), 14'h0000};
            // Bit 13 set to show it cannot be written
            frame(ANPR_OP_WR, p[4:0], ANPR_REG_FEAT, m_feat[p][15:0] | 16'h2000);
        end
        for (int p = 0; p < 4; p++) begin
            rdchk(p, ANPR_REG_LP_NP, m_lp[p][15:0]);
            rdchk6(p);
            rdchk6(p);
            rdchk(p, ANPR_REG_ADV, m_adv[p][15:0]);
            chk("adv_word", m_adv[p][15:0], adv_word[p]);
            rdchk(p, ANPR_REG_FEAT, {m_feat[p][15:14], jam[p], 13'h0000});
        end
        repeat (4) begin
            irq <= 4'($urandom);
            repeat (3) @(posedge ref_clk);
            for (int p = 0; p < 4; p++) begin
                chk("irq_pin", {15'h0000, irq[p] ~^ m_feat[p][14]}, {15'h0000, irq_pin[p]});
            end
        end
        rdchk(2, 5'h08, 16'h0000);
        frame(ANPR_OP_RD, 5'h04, ANPR_REG_EXP, 16'h0000);
        chk("unmatched", 16'hFFFF, rd);
        // Unknown operation code leaves the advert untouched
        frame(2'b11, 5'h00, ANPR_REG_ADV, 16'hFFFF);
        rdchk(0, ANPR_REG_ADV, m_adv[0][15:0]);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
